// file: hw/adc_conversion_sequencer.sv
// Purpose: sequencing and result formatting of an oversampling incremental converter
// Assumes: mod_bit_i is the modulator decision, valid at each sample tick
// Notes: wishbone classic slave, one wait state on every access
`timescale 1ns/1ps
module adc_conversion_sequencer (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic mod_bit_i,
	output logic sample_tick_o,
	output logic integ_reset_o,
	output logic chop_o,
	output logic busy_o,
	output logic conv_done_o,
	output logic [15:0] result_o,
	output logic irq_o
);
	import adc_seq_pkg::*;

	adc_config_t cfg_r;
	adc_config_t run_cfg_r;
	logic start_r;
	logic defstart_r;
	logic [IRQ_W-1:0] irq_status_r;
	logic [IRQ_W-1:0] irq_mask_r;
	conv_result_t res_r;
	logic ack_r;
	logic [31:0] rdata_r;
	seq_state_t state_r;
	logic [10:0] div_cnt_r;
	logic tick_r;
	logic [10:0] phase_r;
	logic [2:0] elem_r;
	logic chop_r;
	logic signed [ACC_W-1:0] acc1_r;
	logic signed [ACC_W-1:0] acc2_r;
	logic signed [ACC_W-1:0] sum_r;
	logic done_r;

	logic req;
	logic wr_ack;
	logic wr_byte0;
	logic wr_byte1;
	logic start_req;
	logic launch;
	logic finish;
	logic [10:0] ratio_run;
	logic [2:0] elem_last;
	logic [10:0] div_top;
	logic signed [ACC_W-1:0] acc1_nxt;
	logic signed [ACC_W-1:0] acc2_nxt;
	logic elem_end;
	logic [4:0] res_theory;
	logic [4:0] res_eff;
	logic signed [WIDE_W-1:0] wide;
	logic signed [WIDE_W-1:0] scaled;
	logic [15:0] low_mask;
	logic [15:0] low_fill;
	conv_result_t res_nxt;
	logic [1:0] rate_sel;
	logic [31:0] ctl_word;
	logic [IRQ_W-1:0] irq_event;

	// bus slave: ack one cycle after the request, dropped the cycle after
	assign req = wb_cyc_i & wb_stb_i;
	assign wr_ack = req & wb_we_i & ack_r;
	assign wr_byte0 = wr_ack & wb_sel_i[0];
	assign wr_byte1 = wr_ack & wb_sel_i[1];
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdata_r;

	// control read word; pending starts read back until a launch takes them
	always_comb begin
		ctl_word = 32'h0000_0000;
		ctl_word[CTL_START_BIT] = start_r;
		ctl_word[CTL_DEFSTART_BIT] = defstart_r;
		ctl_word[CTL_BUSY_BIT] = busy_o;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_r <= 32'h0000_0000;
		end else if (req & ~ack_r) begin
			unique case (wb_adr_i)
				OFS_CONFIG: rdata_r <= {24'h00_0000, cfg_r};
				OFS_CONTROL: rdata_r <= ctl_word;
				OFS_RESULT: rdata_r <= {16'h0000, res_r.code};
				OFS_RES_INFO: rdata_r <= {27'h000_0000, res_r.resolution};
				OFS_IRQ_STATUS: rdata_r <= {30'h0000_0000, irq_status_r};
				OFS_IRQ_MASK: rdata_r <= {30'h0000_0000, irq_mask_r};
				default: rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// configuration; ratio and count take effect at the next launch, continuous at once, rate at once only when idle
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cfg_r <= adc_config_t'(CONFIG_RST);
		end else if (wr_byte0 && wb_adr_i == OFS_CONFIG) begin
			cfg_r <= adc_config_t'(wb_dat_i[7:0]);
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_mask_r <= IRQ_MASK_RST;
		end else if (wr_byte0 && wb_adr_i == OFS_IRQ_MASK) begin
			irq_mask_r <= wb_dat_i[IRQ_W-1:0];
		end
	end

	// start bits: hardware clears on launch, a write in that cycle wins
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			start_r <= 1'b0;
			defstart_r <= 1'b0;
		end else if (wr_byte0 && wb_adr_i == OFS_CONTROL) begin
			start_r <= start_r & ~launch | wb_dat_i[CTL_START_BIT];
			defstart_r <= defstart_r & ~launch | wb_dat_i[CTL_DEFSTART_BIT];
		end else if (launch) begin
			start_r <= 1'b0;
			defstart_r <= 1'b0;
		end
	end

	// events in status-bit order; saturation rides on a finished result only
	always_comb begin
		irq_event = '0;
		irq_event[IRQ_DONE_BIT] = done_r;
		irq_event[IRQ_SAT_BIT] = done_r & res_r.saturated;
	end

	// sticky events, write one to clear; a new event beats the clear
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_status_r <= '0;
		end else begin
			for (int i = 0; i < IRQ_W; i++) begin
				if (irq_event[i]) begin
					irq_status_r[i] <= 1'b1;
				end else if (wr_byte0 && wb_adr_i == OFS_IRQ_STATUS && wb_dat_i[i]) begin
					irq_status_r[i] <= 1'b0;
				end
			end
		end
	end

	// level output; masking never touches the sticky bits
	assign irq_o = |(irq_status_r & irq_mask_r);

	// sample clock divider; runs free so the rate is stable between frames
	// the rate is frozen with ratio and count while a conversion runs; continuous is not
	assign rate_sel = busy_o ? run_cfg_r.sample_freq_sel : cfg_r.sample_freq_sel;
	assign div_top = (FS_DIV_BASE >> rate_sel) - 11'd1;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_cnt_r <= 11'd0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (div_cnt_r == 11'd0);
			div_cnt_r <= (div_cnt_r == 11'd0 || div_cnt_r > div_top) ? div_top :
				div_cnt_r - 11'd1;
		end
	end

	assign sample_tick_o = tick_r;

	// sequence control
	assign ratio_run = RATIO_BASE << run_cfg_r.oversample_ratio_sel;
	assign elem_last = 3'((ELEM_BASE << run_cfg_r.elem_conv_count_sel) - 4'h1);
	assign start_req = start_r | defstart_r | cfg_r.continuous;
	// launches align to a tick so every conversion has the same length
	assign launch = tick_r & start_req & ((state_r == ST_IDLE) | finish);
	assign elem_end = (phase_r == ratio_run);
	assign finish = (state_r == ST_QUANT) & tick_r;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_r <= ST_IDLE;
		end else begin
			unique case (state_r)
				ST_IDLE: if (launch) begin
					state_r <= ST_RUN;
				end
				ST_RUN: if (tick_r && elem_end && elem_r == elem_last) begin
					state_r <= ST_QUANT;
				end
				// a start written while busy launches again right here
				ST_QUANT: if (tick_r) begin
					state_r <= launch ? ST_RUN : ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			run_cfg_r <= adc_config_t'(CONFIG_RST);
		end else if (launch) begin
			run_cfg_r <= cfg_r;
		end
	end

	// element timing: phase 0 resets the integrators, 1..ratio integrate
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			phase_r <= 11'd0;
			elem_r <= 3'd0;
			chop_r <= 1'b0;
		end else if (launch) begin
			phase_r <= 11'd0;
			elem_r <= 3'd0;
			chop_r <= 1'b0;
		end else if (state_r == ST_RUN && tick_r) begin
			if (elem_end) begin
				phase_r <= 11'd0;
				elem_r <= elem_r + 3'd1;
				chop_r <= ~chop_r;
			end else begin
				phase_r <= phase_r + 11'd1;
			end
		end
	end

	assign integ_reset_o = (state_r == ST_RUN) & (phase_r == 11'd0);
	assign chop_o = chop_r;
	assign busy_o = (state_r != ST_IDLE);

	// second order incremental accumulation
	assign acc1_nxt = acc1_r + (mod_bit_i ? ACC_W'(1) : -ACC_W'(1));
	assign acc2_nxt = acc2_r + acc1_nxt;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			acc1_r <= '0;
			acc2_r <= '0;
		end else if (state_r == ST_RUN && tick_r) begin
			if (phase_r == 11'd0) begin
				acc1_r <= '0;
				acc2_r <= '0;
			end else begin
				acc1_r <= acc1_nxt;
				acc2_r <= acc2_nxt;
			end
		end
	end

	// chopped elements are subtracted so the amplifier offset cancels
	// the widest element sum stays far inside the accumulator width
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sum_r <= '0;
		end else if (launch) begin
			sum_r <= '0;
		end else if (state_r == ST_RUN && tick_r && elem_end && phase_r != 11'd0) begin
			sum_r <= chop_r ? sum_r - acc2_nxt : sum_r + acc2_nxt;
		end
	end

	// formatting: sum spans 2^(n-1), so shift by 16-n to full scale
	always_comb begin
		res_theory = RES_BASE + {1'b0, run_cfg_r.oversample_ratio_sel, 1'b0}
			+ {3'h0, run_cfg_r.elem_conv_count_sel};
		res_eff = (res_theory > RES_MAX) ? RES_MAX : res_theory;
		wide = WIDE_W'(sum_r);
		if (res_theory <= RES_MAX) begin
			scaled = wide <<< (RES_MAX - res_theory);
		end else begin
			scaled = wide >>> (res_theory - RES_MAX);
		end
		low_mask = 16'hFFFF >> res_eff;
		low_fill = (res_eff < RES_MAX) ? (16'h8000 >> res_eff) : 16'h0000;
		res_nxt.resolution = res_eff;
		res_nxt.saturated = 1'b0;
		// saturated codes skip the low-bit forcing so full scale stays exact
		if (scaled > CODE_POS_MAX) begin
			res_nxt.code = CODE_POS_SAT;
			res_nxt.saturated = 1'b1;
		end else if (scaled < CODE_NEG_MAX) begin
			res_nxt.code = CODE_NEG_SAT;
			res_nxt.saturated = 1'b1;
		end else begin
			res_nxt.code = (scaled[15:0] & ~low_mask) | low_fill;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			res_r <= '0;
		end else if (finish) begin
			res_r <= res_nxt;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			done_r <= 1'b0;
		end else begin
			done_r <= finish;
		end
	end

	assign conv_done_o = done_r;
	assign result_o = res_r.code;

endmodule // adc_conversion_sequencer

// file: hw/adc_seq_pkg.sv
// Purpose: shared constants and types for the conversion sequencer
// Assumes: 125 MHz system clock, classic wishbone register access
// Notes: byte offsets are word aligned; all register fields sit in low bits
package adc_seq_pkg;

	// clock and sampling timing
	localparam int CLK_HZ = 125_000_000;
	localparam int FS_MIN_HZ = 62_500;
	localparam logic [10:0] FS_DIV_BASE = 11'(CLK_HZ / FS_MIN_HZ);

	// converter parameters
	localparam logic [10:0] RATIO_BASE = 11'h008;
	localparam logic [3:0] ELEM_BASE = 4'h1;
	localparam logic [4:0] RES_BASE = 5'h06;
	localparam logic [4:0] RES_MAX = 5'h10;
	localparam int ACC_W = 26;
	localparam int WIDE_W = 40;
	localparam logic signed [WIDE_W-1:0] CODE_POS_MAX = 40'sh00_0000_7FFF;
	localparam logic signed [WIDE_W-1:0] CODE_NEG_MAX = -40'sh00_0000_8000;
	localparam logic [15:0] CODE_POS_SAT = 16'h7FFF;
	localparam logic [15:0] CODE_NEG_SAT = 16'h8000;

	// register byte offsets
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_CONTROL = 8'h04;
	localparam logic [7:0] OFS_RESULT = 8'h08;
	localparam logic [7:0] OFS_RES_INFO = 8'h0C;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

	// field positions
	localparam int CTL_START_BIT = 0;
	localparam int CTL_DEFSTART_BIT = 1;
	localparam int CTL_BUSY_BIT = 8;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_SAT_BIT = 1;
	localparam int IRQ_W = 2;

	// reset values
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

	typedef struct packed {
		logic continuous;
		logic [1:0] sample_freq_sel;
		logic [1:0] elem_conv_count_sel;
		logic [2:0] oversample_ratio_sel;
	} adc_config_t;

	typedef struct packed {
		logic [15:0] code;
		logic [4:0] resolution;
		logic saturated;
	} conv_result_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_QUANT = 2'b11
	} seq_state_t;

endpackage

// file: verif/adc_conversion_sequencer_chk.sv
// Purpose: port-level checks of the conversion sequencer
// Assumes: mode and start requests are seen as bus writes at ack
// Notes: mode is tracked from bus traffic, not from internals
`timescale 1ns/1ps
module adc_conversion_sequencer_chk
	import adc_seq_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic sample_tick_o,
	input wire logic integ_reset_o,
	input wire logic chop_o,
	input wire logic busy_o,
	input wire logic conv_done_o,
	input wire logic [15:0] result_o
);
	import adc_seq_pkg::*;
	logic cont_r;
	logic go_r;
	logic wr_ack;
	assign wr_ack = wb_ack_o && wb_cyc_i && wb_we_i && wb_sel_i[0];
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cont_r <= 1'b0;
		end else if (wr_ack && wb_adr_i == OFS_CONFIG) begin
			cont_r <= wb_dat_i[7];
		end
	end
	// a start written while busy stays pending, so only a launch consumes it
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			go_r <= 1'b0;
		end else if (wr_ack && wb_adr_i == OFS_CONTROL && wb_dat_i[1:0] != 2'h0) begin
			go_r <= 1'b1;
		end else if ($rose(busy_o)) begin
			go_r <= 1'b0;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	sequence bus_req;
		$rose(wb_cyc_i && wb_stb_i);
	endsequence
	sequence launch;
		$rose(busy_o);
	endsequence
	ack_answer_a: assert property (bus_req |=> wb_ack_o) else $error("late ack");
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	done_pulse_a: assert property (conv_done_o |=> !conv_done_o) else $error("long done");
	done_tick_a: assert property (conv_done_o |-> $past(sample_tick_o) && $past(busy_o))
		else $error("done off tick");
	result_done_a: assert property ($changed(result_o) |-> ##[0:1] conv_done_o)
		else $error("result without done");
	launch_cause_a: assert property (launch |-> go_r || cont_r) else $error("unrequested run");
	req_stop_a: assert property (conv_done_o && !cont_r && !go_r |-> !busy_o)
		else $error("request mode kept running");
	cont_restart_a: assert property (conv_done_o && cont_r |-> busy_o)
		else $error("no restart");
	first_chop_a: assert property (launch |-> !chop_o) else $error("chop not zero");
	integ_busy_a: assert property ($fell(integ_reset_o) |-> $past(sample_tick_o) && busy_o)
		else $error("reset phase not one tick");
endmodule // adc_conversion_sequencer_chk
bind adc_conversion_sequencer adc_conversion_sequencer_chk u_adc_conversion_sequencer_chk (
	.clk_i, .arst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
	.wb_ack_o, .sample_tick_o, .integ_reset_o, .chop_o, .busy_o, .conv_done_o, .result_o
);

// file: verif/adc_conversion_sequencer_test.sv
// Purpose: directed bench for the conversion sequencer
// Assumes: fastest sample rate, 250 clocks per tick
// Notes: modulator toggles each tick, or is held high or low to reach full scale
`timescale 1ns/1ps
module adc_conversion_sequencer_test;
	import adc_seq_pkg::*;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic mod_bit_i = 1'b0;
	logic [31:0] wb_dat_o;
	logic [15:0] result_o;
	logic wb_ack_o, sample_tick_o, integ_reset_o, chop_o, busy_o, conv_done_o, irq_o;
	logic [31:0] rd;
	int err_count = 0;
	int samples_checked = 0;
	int ticks_run = 0;
	int ticks_last = 0;
	int mod_mode = 0;
	always #4 clk_i = ~clk_i;
	adc_conversion_sequencer u_adc_conversion_sequencer (
		.clk_i, .arst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .mod_bit_i, .sample_tick_o, .integ_reset_o, .chop_o,
		.busy_o, .conv_done_o, .result_o, .irq_o
	);
	// ticks while busy, per conversion; the launch tick falls before busy
	always @(posedge clk_i) begin
		if (sample_tick_o === 1'b1) begin
			mod_bit_i <= (mod_mode == 0) ? ~mod_bit_i : (mod_mode == 1);
		end
		if (conv_done_o === 1'b1) begin
			ticks_last <= ticks_run;
			ticks_run <= 0;
		end else if (busy_o === 1'b1 && sample_tick_o === 1'b1) begin
			ticks_run <= ticks_run + 1;
		end
	end
	task final_report;
		$display("mismatches %0d, checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			err_count++;
			final_report();
		end
	endtask
	task wait_done;
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (conv_done_o !== 1'b1 && n < 30000);
		if (conv_done_o !== 1'b1) begin
			err_count++;
			final_report();
		end
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		arst_n_i <= 1'b1;
		bus(1'b0, OFS_CONFIG, 32'h0);
		chk(rd, {24'h0, CONFIG_RST});
		bus(1'b0, OFS_IRQ_MASK, 32'h0);
		chk(rd, {30'h0, IRQ_MASK_RST});
		bus(1'b0, 8'h1C, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, OFS_IRQ_MASK, 32'h1);
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, OFS_CONFIG, 32'(8'h60 | (k << 3)));
			bus(1'b1, OFS_CONTROL, (k == 1) ? 32'h2 : 32'h1);
			wait_done();
			bus(1'b0, OFS_RES_INFO, 32'h0);
			chk(32'(ticks_last), 32'((1 << k) * 9 + 1));
			chk(rd, 32'(6 + k));
			chk({16'h0, result_o} & ((32'h1 << (10 - k)) - 1), 32'h1 << (9 - k));
			chk({31'h0, irq_o}, 32'h1);
			bus(1'b1, OFS_IRQ_STATUS, 32'h1);
			repeat (2) @(posedge clk_i);
			chk({31'h0, irq_o}, 32'h0);
		end
		for (int s = 1; s < 3; s++) begin
			mod_mode <= s;
			bus(1'b1, OFS_CONFIG, 32'h60);
			bus(1'b1, OFS_CONTROL, 32'h1);
			wait_done();
			bus(1'b0, OFS_IRQ_STATUS, 32'h0);
			chk({16'h0, result_o}, {16'h0, ((s == 1) ? CODE_POS_SAT : CODE_NEG_SAT)});
			chk(rd, 32'h3);
			bus(1'b1, OFS_IRQ_STATUS, 32'h3);
		end
		mod_mode <= 0;
		bus(1'b1, OFS_IRQ_MASK, 32'h0);
		bus(1'b1, OFS_CONFIG, 32'hE8);
		wait_done();
		wait_done();
		bus(1'b1, OFS_CONFIG, 32'h60);
		chk(32'(ticks_last), 32'(2 * 9 + 1));
		chk({31'h0, irq_o}, 32'h0);
		bus(1'b0, OFS_IRQ_STATUS, 32'h0);
		chk(rd & 32'h1, 32'h1);
		wait_done();
		repeat (600) @(posedge clk_i);
		chk({31'h0, busy_o}, 32'h0);
		final_report();
	end
endmodule // adc_conversion_sequencer_test
